// *** clkctl.sv ***
// clocking, sync, power and output timing of a quad pipelined receiver
// assumes sample clock equals mclk; inputs synchronous to mclk; pads resolve enables
// Summary of operation
// [R01] divide sample clock by 1 to 8
// [R02] control bit 1 resyncs on every pulse
// [R03] honoured pulse returns divider to initial state
// [R04] alignment pulse passes internal synchronizer first
// [R05] driver makes pulse synchronous to clock
// [R06] stabilizer regenerates falling edge, 50% high; code holds odd ratios 3, 5, 7 high half a cycle short of 50%
// [R07] stabilizer need not work below 40 MHz
// [R08] relock takes 1.5 to 5 us
// [R09] unlocked stabilizer is bypassed, raw duty used
// [R10] power-down from pin or serial control
// [R11] power-down floats all output drivers
// [R12] pin low returns to normal operation
// [R13] power-down stops clock; wake grows with time
// [R14] standby keeps reference up, faster wake
// [R15] outputs are double data rate
// [R16] setting selects offset binary or twos complement
// [R17] output exactly nine cycles after sampling
// [R18] output updates after rising edge
// [R19] input sampled on rising internal clock edge
// [R20] strobe high carries A/C, low carries B/D
// [R21] zero input: 100.. offset, 000.. twos
// [R22] ratio defaults to one, loads at initial state
`default_nettype none
module clkctl #(
	parameter int unsigned RELOCK_CYCLES = clkctl_pkg::RELOCK_CYC,
	parameter int unsigned LAT = clkctl_pkg::LATENCY
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// sync and clock setup
	input wire logic sync_in,
	input wire logic resync_every,
	input wire logic [2:0] div_ratio_m1,
	input wire logic freq_change,
	input wire logic stabilizer_en,
	input wire logic raw_clk_level,
	// power control
	input wire logic power_down_pin,
	input wire logic power_down_ctrl,
	input wire logic standby_ctrl,
	// data path
	input wire logic [10:0] sample_a,
	input wire logic [10:0] sample_b,
	input wire logic [10:0] sample_c,
	input wire logic [10:0] sample_d,
	input wire logic twos_comp,
	// status and outputs
	output logic internal_clk,
	output logic divider_tick,
	output logic stabilizer_locked,
	output logic powered_down,
	output logic reference_on,
	output logic [10:0] ddr_data,
	output logic [10:0] ddr_data_oe,
	output logic capture_strobe_out,
	output logic capture_strobe_oe
);
	localparam int unsigned CW = 16;
	// offset binary in; twos complement flips the top bit only
	function automatic logic [10:0] fmt(input logic [10:0] s, input logic tc);
		fmt = tc ? (s ^ clkctl_pkg::MID_CODE) : s;
	endfunction : fmt
	// synchronizer: two flops, then an edge detector on the clean copy
	logic sync_m_q;
	logic sync_s_q;
	logic sync_p_q;
	logic sync_seen_q;
	wire sync_rise;
	wire sync_first;
	wire sync_honour;
	assign sync_rise = sync_s_q & ~sync_p_q;
	assign sync_first = ~sync_seen_q;
	assign sync_honour = sync_rise & (resync_every | sync_first); // see [R02]
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sync_m_q <= 1'b0;
		end else begin
			sync_m_q <= sync_in; // see [R04]
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sync_s_q <= 1'b0;
			sync_p_q <= 1'b0;
		end else begin
			sync_s_q <= sync_m_q;
			sync_p_q <= sync_s_q;
		end
	end
	// first-pulse memory; only reset clears it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sync_seen_q <= 1'b0;
		end else if (sync_rise) begin
			sync_seen_q <= 1'b1;
		end
	end
	// divider; ratio loads only at the initial state so no period is cut short
	logic [2:0] div_cnt_q;
	logic [2:0] div_lim_q;
	wire clk_run;
	wire div_wrap;
	wire tick;
	wire [2:0] div_next;
	assign div_wrap = div_cnt_q == div_lim_q;
	assign div_next = div_wrap ? clkctl_pkg::DIV_RESET : div_cnt_q + 3'h1; // see [R01]
	assign tick = clk_run & div_wrap;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_q <= clkctl_pkg::DIV_RESET;
		end else if (sync_honour) begin
			div_cnt_q <= clkctl_pkg::DIV_RESET; // see [R03]
		end else if (clk_run) begin
			div_cnt_q <= div_next; // see [R01]
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			div_lim_q <= clkctl_pkg::DIV_RESET; // see [R22]
		end else if (sync_honour || (clk_run && div_wrap)) begin
			div_lim_q <= div_ratio_m1; // see [R22]
		end
	end
	// stabilizer lock; any frequency change or stop restarts the count
	// no rate detector: below about 40 MHz the stabilizer is simply left off
	logic [CW-1:0] lock_cnt_q;
	logic locked_q;
	wire lock_clear;
	wire lock_done;
	assign lock_clear = freq_change | ~stabilizer_en | ~clk_run; // see [R07]
	assign lock_done = lock_cnt_q >= CW'(RELOCK_CYCLES - 1);
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lock_cnt_q <= '0;
		end else if (lock_clear) begin
			lock_cnt_q <= '0;
		end else if (!locked_q) begin
			lock_cnt_q <= lock_cnt_q + 1'b1; // see [R08]
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			locked_q <= 1'b0;
		end else if (lock_clear) begin
			locked_q <= 1'b0;
		end else if (!locked_q) begin
			locked_q <= lock_done; // see [R08]
		end
	end
	// 50% phase when locked, high half a cycle short of it at odd ratios 3, 5, 7; four bits so divide-by-8 does not wrap to zero
	logic half_q;
	wire [3:0] half_len;
	wire half_pt;
	wire even_one;
	wire half_next;
	assign half_len = ({1'b0, div_lim_q} + 4'h1) >> 1;
	assign half_pt = {1'b0, div_cnt_q} < half_len; // see [R06]
	assign even_one = div_lim_q == 3'h0;
	assign half_next = even_one ? ~half_q : half_pt;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			half_q <= 1'b0;
		end else if (locked_q) begin
			half_q <= half_next; // see [R06]
		end else begin
			half_q <= raw_clk_level; // see [R09]
		end
	end
	// power state; wake time tracks time spent down
	clkctl_pkg::pwr_state_type pst_q;
	logic [9:0] down_cnt_q;
	logic [9:0] wake_cnt_q;
	wire pd_req;
	wire sb_req;
	wire [9:0] wake_load;
	assign pd_req = power_down_pin | power_down_ctrl; // see [R10]
	assign sb_req = standby_ctrl & ~pd_req;
	assign clk_run = pst_q == clkctl_pkg::pwr_run_type_run;
	// standby kept the reference up, so only a short fixed wake
	assign wake_load = (pst_q == clkctl_pkg::pwr_run_type_standby) ?
		10'(clkctl_pkg::STANDBY_WAKE_CYC) : (down_cnt_q >> clkctl_pkg::WAKE_SHIFT); // see [R13] see [R14]
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pst_q <= clkctl_pkg::pwr_run_type_run;
			down_cnt_q <= '0;
			wake_cnt_q <= '0;
		end else begin
			case (pst_q)
				clkctl_pkg::pwr_run_type_run: begin
					down_cnt_q <= '0;
					if (pd_req) begin
						pst_q <= clkctl_pkg::pwr_run_type_down;
					end else if (sb_req) begin
						pst_q <= clkctl_pkg::pwr_run_type_standby;
					end
				end
				clkctl_pkg::pwr_run_type_down, clkctl_pkg::pwr_run_type_standby: begin
					if (down_cnt_q != 10'h3FF) begin
						down_cnt_q <= down_cnt_q + 10'h1;
					end
					if (pd_req) begin
						pst_q <= clkctl_pkg::pwr_run_type_down;
					end else if (!sb_req) begin
						pst_q <= clkctl_pkg::pwr_run_type_wake; // see [R12]
						wake_cnt_q <= wake_load;
					end else begin
						pst_q <= clkctl_pkg::pwr_run_type_standby;
					end
				end
				clkctl_pkg::pwr_run_type_wake: begin
					if (pd_req) begin
						pst_q <= clkctl_pkg::pwr_run_type_down;
					end else if (wake_cnt_q == 10'h0) begin
						pst_q <= clkctl_pkg::pwr_run_type_run;
					end else begin
						wake_cnt_q <= wake_cnt_q - 10'h1;
					end
				end
				default: begin
					pst_q <= clkctl_pkg::pwr_run_type_run;
				end
			endcase
		end
	end
	// nine-deep pipeline of sample and valid; valid is dropped when stopped
	logic [4*11-1:0] pipe_q [LAT];
	logic [LAT-1:0] pv_q;
	wire [43:0] word_in;
	assign word_in = {fmt(sample_a, twos_comp), fmt(sample_b, twos_comp),
		fmt(sample_c, twos_comp), fmt(sample_d, twos_comp)}; // see [R16] see [R21]
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pv_q <= '0;
		end else if (!clk_run) begin
			pv_q <= '0;
		end else begin
			pv_q <= {pv_q[LAT-2:0], tick}; // see [R17] see [R19]
		end
	end
	// data flops carry no reset: valid alone says what is meaningful
	always_ff @(posedge mclk) begin
		pipe_q[0] <= word_in; // see [R19]
		for (int i = 1; i < LAT; i++) begin
			pipe_q[i] <= pipe_q[i-1];
		end
	end
	// ddr: A with strobe high, then B, C, D on alternating strobe phases
	// a new word always restarts the strobe high, even after an odd gap
	logic [43:0] hold_q;
	wire [43:0] last;
	wire word_due;
	assign last = pipe_q[LAT-1];
	assign word_due = pv_q[LAT-1];
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hold_q <= '0;
		end else if (word_due) begin
			hold_q <= {last[32:0], last[43:33]};
		end else begin
			hold_q <= {hold_q[32:0], hold_q[43:33]}; // see [R15]
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ddr_data <= '0;
		end else if (word_due) begin
			ddr_data <= last[43:33]; // see [R15] see [R18]
		end else begin
			ddr_data <= hold_q[43:33]; // see [R15]
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			capture_strobe_out <= 1'b0;
		end else if (word_due) begin
			capture_strobe_out <= 1'b1; // see [R20]
		end else begin
			capture_strobe_out <= ~capture_strobe_out; // see [R20]
		end
	end
	// pad enables and status, all straight from flops
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ddr_data_oe <= '0;
			capture_strobe_oe <= 1'b0;
		end else begin
			ddr_data_oe <= {11{clk_run}}; // see [R11]
			capture_strobe_oe <= clk_run; // see [R11]
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			internal_clk <= 1'b0;
			divider_tick <= 1'b0;
		end else begin
			internal_clk <= clk_run & half_q; // see [R13]
			divider_tick <= tick;
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stabilizer_locked <= 1'b0;
		end else begin
			stabilizer_locked <= locked_q; // see [R09]
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			powered_down <= 1'b0;
			reference_on <= 1'b1;
		end else begin
			powered_down <= pst_q == clkctl_pkg::pwr_run_type_down;
			reference_on <= pst_q != clkctl_pkg::pwr_run_type_down; // see [R14]
		end
	end
endmodule : clkctl
`default_nettype wire

// *** clkctl_pkg.sv ***
// package for the receiver clocking and control block: constants and state types
// assumes a single 50 MHz mclk domain; no bus, all controls are ports
`default_nettype none
package clkctl_pkg;
	localparam int unsigned MCLK_HZ = 50000000;
	localparam int unsigned DIV_W = 3;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam int unsigned SAMPLE_W = 11;
	localparam int unsigned CHANNELS = 4;
	localparam int unsigned LATENCY = 9;
	localparam int unsigned RESYNC_EVERY_BIT = 1;
	localparam logic [7:0] SYNC_CTRL_ADDR = 8'h3A;
	localparam int unsigned RELOCK_MIN_NS = 1500;
	localparam int unsigned RELOCK_MAX_NS = 5000;
	localparam int unsigned RELOCK_CYC = (RELOCK_MAX_NS * (MCLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned STAB_MIN_HZ = 40000000;
	localparam int unsigned WAKE_MAX = 1023;
	localparam int unsigned WAKE_SHIFT = 2;
	localparam int unsigned STANDBY_WAKE_CYC = 4;
	localparam logic [10:0] MID_CODE = 11'h400;
	typedef enum logic [1:0] {
		pwr_run_type_run = 2'b00,
		pwr_run_type_down = 2'b01,
		pwr_run_type_standby = 2'b10,
		pwr_run_type_wake = 2'b11
	} pwr_state_type;
endpackage : clkctl_pkg
`default_nettype wire

// *** clkctl_properties.sv ***
// checker for clkctl: power, strobe, lock and divider relations
// assumes bind onto clkctl ports, one mclk domain
`default_nettype none
module clkctl_props (
	// clock and controls
	input wire logic mclk,
	input wire logic resetn,
	input wire logic freq_change,
	input wire logic power_down_pin,
	input wire logic power_down_ctrl,
	input wire logic [2:0] div_ratio_m1,
	// observed outputs
	input wire logic divider_tick,
	input wire logic internal_clk,
	input wire logic stabilizer_locked,
	input wire logic powered_down,
	input wire logic reference_on,
	input wire logic [10:0] ddr_data_oe,
	input wire logic capture_strobe_out,
	input wire logic capture_strobe_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence down_req;
		power_down_pin || power_down_ctrl;
	endsequence
	a_pd_float: assert property (powered_down |-> ddr_data_oe == 11'h000 && !capture_strobe_oe)
		else $error("driven while down");
	a_down_enter: assert property (down_req |-> ##[1:2] powered_down)
		else $error("down request ignored");
	a_down_ref: assert property (down_req |-> ##[1:2] !reference_on)
		else $error("reference kept in down");
	a_strobe_ddr: assert property (capture_strobe_oe && $past(capture_strobe_oe) && !$past(capture_strobe_out) |-> capture_strobe_out)
		else $error("strobe stayed low");
	a_relock_wait: assert property (freq_change |=> ##1 !stabilizer_locked)
		else $error("locked after change");
	a_tick_gap: assert property (divider_tick && div_ratio_m1 != 3'h0 |=> !divider_tick)
		else $error("tick too soon");
	a_pin_wake: assert property ($fell(powered_down) |-> !$past(power_down_pin) && !$past(power_down_ctrl))
		else $error("woke while requested");
	a_oe_group: assert property (capture_strobe_oe |-> ddr_data_oe == 11'h7FF)
		else $error("data oe split");
	a_clk_stop: assert property (powered_down |-> !internal_clk)
		else $error("clock runs while down");
endmodule : clkctl_props
bind clkctl clkctl_props props (.*);
`default_nettype wire

// *** clk_src.sv ***
// partner: source clock level and aligned sync pulses
// assumes mclk stands for the sample clock
`default_nettype none
module clk_src (
	input wire logic mclk,
	input wire logic go,
	output logic sync_in,
	output logic raw_clk_level
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	initial sync_in = 1'b0;
	assign raw_clk_level = mclk;
	always @(posedge mclk) begin
		n <= n + 1;
		sync_in <= go && n[4:0] == 5'h00;
	end
endmodule : clk_src
`default_nettype wire

// *** tb_clkctl.sv ***
// bench for clkctl: data timing, format, power, lock
// assumes clk_src partner and bound checker
`default_nettype none
module tb_clkctl;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, resetn, go, sync_in, resync_every, freq_change, stabilizer_en, raw_clk_level;
	logic power_down_pin, power_down_ctrl, standby_ctrl, twos_comp, on;
	logic [2:0] div_ratio_m1;
	logic [10:0] sample_a, sample_b, sample_c, sample_d, ddr_data, ddr_data_oe;
	logic internal_clk, divider_tick, stabilizer_locked, powered_down, reference_on;
	logic capture_strobe_out, capture_strobe_oe;
	logic [43:0] h[16];
	bit ht[16];
	int errors, n_checks, cyc, j;
	clk_src src (.*);
	clkctl #(.RELOCK_CYCLES(4)) dut (.*);
	task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// reference model: word pushed at tick, due nine cycles on
	always @(negedge mclk) begin
		cyc++;
		for (int i = 0; i < 4; i++) begin
			j = (cyc - 9 - i) & 15;
			if (ht[j] && capture_strobe_oe === 1'b1) begin
				chk("ddr_data", ddr_data, h[j][43 - 11 * i -: 11] ^ {twos_comp, 10'h000});
				chk("strobe", 11'(capture_strobe_out), 11'(i % 2 == 0));
			end
		end
		ht[cyc & 15] = on && divider_tick;
		h[cyc & 15] = {sample_a, sample_b, sample_c, sample_d};
		{sample_a, sample_b, sample_c, sample_d} = 44'({$urandom, $urandom});
	end
	initial begin
		void'($urandom(32'h1ba9));
		{resetn, go, resync_every, freq_change, stabilizer_en, power_down_pin, power_down_ctrl} = 7'h00;
		{standby_ctrl, twos_comp, on, sample_a, sample_b, sample_c, sample_d} = 47'h0;
		div_ratio_m1 = 3'h3;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		resetn = 1'b1;
		{go, resync_every, stabilizer_en} = 3'h7;
		for (int m = 0; m < 2; m++) begin
			twos_comp = m[0];
			on = 1'b1;
			repeat (60) @(negedge mclk);
			chk("strobe_oe", 11'(capture_strobe_oe), 11'h001);
			on = 1'b0;
			repeat (14) @(negedge mclk);
		end
		// pin, serial down, then standby
		for (int m = 0; m < 3; m++) begin
			{power_down_pin, power_down_ctrl, standby_ctrl} = 3'(4 >> m);
			repeat (4) @(negedge mclk);
			chk("data_oe", ddr_data_oe, 11'h000);
			chk("reference_on", 11'(reference_on), 11'(m == 2));
			{power_down_pin, power_down_ctrl, standby_ctrl} = 3'h0;
			for (int w = 0; w < 400 && capture_strobe_oe !== 1'b1; w++)
				@(negedge mclk);
			chk("wake", 11'(capture_strobe_oe), 11'h001);
		end
		freq_change = 1'b1;
		@(negedge mclk);
		freq_change = 1'b0;
		@(negedge mclk);
		chk("locked", 11'(stabilizer_locked), 11'h000);
		repeat (12) @(negedge mclk);
		chk("locked", 11'(stabilizer_locked), 11'h001);
		report_and_stop();
	end
	initial begin
		#50us;
		errors++;
		report_and_stop();
	end
endmodule : tb_clkctl
`default_nettype wire
